// ---- hw/tpo_pkg.sv ----
// shared constants and types of the trace streaming unit
// assumes one bus clock and a byte wide plain register port
package tpo_pkg;
   localparam logic [15:0] TPO_OFS_DATA0 = 16'h0118;
   localparam logic [15:0] TPO_OFS_DATA3 = 16'h011B;
   localparam logic [15:0] TPO_OFS_MASK0 = 16'h011C;
   localparam logic [15:0] TPO_OFS_MASK3 = 16'h011F;
   localparam logic [15:0] TPO_OFS_CTRL = 16'h0120;
   localparam logic [15:0] TPO_OFS_STAT = 16'h0121;
   localparam logic [15:0] TPO_OFS_TBUF = 16'h0122;
   localparam logic [15:0] TPO_OFS_LCNT = 16'h0123;
   // trace_control_low fields
   localparam int TPO_CTL_ARM = 0;
   localparam int TPO_CTL_STREAM = 1;
   localparam int TPO_CTL_PINS = 2;
   localparam int TPO_CTL_TIMESTAMP_ENABLE_BIT = 3;
   localparam int TPO_CTL_ALIGN_LO = 4;
   // status fields
   localparam int TPO_ST_BUSY = 0;
   localparam int TPO_ST_OVF = 1;
   localparam int TPO_ST_ARMED = 2;
   localparam logic [31:0] TPO_CMP_RESET = 32'h0000_0000;
   localparam logic [31:0] TPO_MASK_RESET = 32'h0000_0000;
   localparam logic [7:0] TPO_CTRL_RESET = 8'h00;
   localparam logic [7:0] TPO_TBUF_BUSY_CODE = 8'hEE;
   localparam logic [1:0] TPO_ALIGN_END = 2'h0;
   localparam logic [1:0] TPO_ALIGN_MID = 2'h1;
   localparam logic [1:0] TPO_ALIGN_BEGIN = 2'h2;
   // info byte of an entry
   localparam int TPO_INFO_EXTERNAL_EVENT_INDICATOR = 7;
   localparam int TPO_INFO_TIMESTAMP_ENABLE_BIT = 6;
   localparam logic [1:0] TPO_KIND_SOURCE = 2'h1;
   localparam logic [1:0] TPO_KIND_DEST = 2'h2;
   localparam logic [1:0] TPO_KIND_VECTOR = 2'h3;
   localparam int TPO_LINES = 64;
   localparam int TPO_LINE_BITS = 64;
   localparam logic [5:0] TPO_LAST_BIT = 6'h3F;

   typedef struct packed {
      logic valid;
      logic [1:0] kind;
      logic [23:0] addr;
   } tpo_cof_t;

   typedef enum logic [2:0] {
      TPO_TX_IDLE = 3'b001,
      TPO_TX_LOW = 3'b010,
      TPO_TX_HIGH = 3'b100
   } tpo_tx_t;
endpackage : tpo_pkg

// ---- hw/tpo_trace.sv ----
// trace streaming unit: comparator A data/mask, 64 line trace buffer,
// serial streaming of buffered change_of_flow entries with offset clock
// assumes cpu side inputs share clk_sys; the event pin is asynchronous
//
// Notes on behaviour
// [RL1] comparator data readable always; writes only when disarmed and not streaming
// [RL2] comparator data at 0x0118..0x011B, bytewise, lowest address holds MSB
// [RL3] each data bit compares bus bit to 1 or 0 where mask bit is 1
// [RL4] indexed jump destination is stored even when an interrupt follows
// [RL5] two entries per line; counter bit 0 steps per entry; info marks kind
// [RL6] external event forces entry with last pc and indicator; coincidence gives one
// [RL7] timestamp enable switches entries to timestamped format
// [RL8] buffer line is eight bytes wide
// [RL9] data pin moves on bus clock; output clock edges fall between
// [RL10] buffer shifted out LSB first while new entries keep arriving
// [RL11] transmission starts in first cycle with no buffer write
// [RL12] output clock holds level while next line is not ready
// [RL13] streaming needs enable bit and arming; pins need pin enable bit
// [RL14] end alignment starts streaming at arming
// [RL15] begin alignment starts at final state, runs until disarm or overflow
// [RL16] mid alignment with streaming acts as end alignment
// [RL17] capture stops on overflow or disarm; sending finishes stored lines
// [RL18] status shows streaming busy and buffer overflow
// [RL19] timestamps only in the two streaming formats
// [RL20] buffer gating and the gating pin are ignored while streaming
// [RL21] disarmed while sending: all register writes are blocked
// [RL22] disarmed while sending: buffer read port returns 0xEE
// [RL23] capture tool samples data on output clock, tolerates pauses
//
// Implementation choice: the plain strobed port.
module tpo_trace
   import tpo_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // cpu trace side
   input wire tpo_cof_t cof_in,
   input wire logic [23:0] last_pc,
   input wire logic seq_final_state,
   input wire logic seq_to_state0,
   input wire logic [31:0] bus_data,
   input wire logic bus_valid,
   output logic comparator_a_hit,
   // external event pin
   input wire logic ext_event_pin,
   // stream pins
   output logic stream_data_pin_o,
   output logic stream_data_pin_oe,
   output logic stream_clock_pin_o,
   output logic stream_clock_pin_oe
);
   logic [31:0] comparator_a_match_data_reg;
   logic [31:0] comparator_a_match_mask_reg;
   logic [7:0] trace_control_low_reg;
   logic armed_reg;
   logic started_reg;
   logic buffer_overflow_flag_reg;
   logic stream_busy_flag_reg;
   logic [2:0] ev_sync_reg;
   logic [31:0] timestamp_enable_bit_reg;
   logic [63:0] buf_mem [TPO_LINES];
   logic [6:0] wr_line_reg;
   logic wr_half_reg;
   logic [6:0] rd_line_reg;
   logic [2:0] tbr_ptr_reg;
   logic [63:0] shift_reg;
   logic [5:0] bit_cnt_reg;
   tpo_tx_t tx_reg;

   function automatic logic [1:0] byte_sel(input logic [15:0] a, input logic [15:0] base);
      logic [15:0] d;
      d = a - base;
      byte_sel = 2'h3 - d[1:0];
   endfunction : byte_sel

   function automatic logic in_word(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
      in_word = (a >= lo) && (a <= hi);
   endfunction : in_word

   logic [1:0] align_eff;
   logic stream_en;
   logic timestamp_enable_bit_en;
   logic capturing;
   logic write_block;
   logic cmp_write_ok;
   logic ext_pulse;
   logic buf_req;
   logic buf_we;
   logic [6:0] lines_pending;
   logic line_ready;
   logic flush;
   logic tx_load;
   logic [31:0] entry;
   logic [7:0] info;

   assign stream_en = trace_control_low_reg[TPO_CTL_STREAM];
   assign timestamp_enable_bit_en = trace_control_low_reg[TPO_CTL_TIMESTAMP_ENABLE_BIT];
   // mid alignment cannot stream, so it falls back to end alignment
   assign align_eff = (trace_control_low_reg[TPO_CTL_ALIGN_LO +: 2] == TPO_ALIGN_MID)
                      ? TPO_ALIGN_END : trace_control_low_reg[TPO_CTL_ALIGN_LO +: 2]; // RL16
   // gating inputs are not consulted at all while capturing
   assign capturing = armed_reg && stream_en && started_reg
                      && !buffer_overflow_flag_reg; // RL13 RL17 RL20
   assign write_block = !armed_reg && stream_busy_flag_reg; // RL21
   assign cmp_write_ok = !armed_reg && !stream_busy_flag_reg; // RL1
   assign ext_pulse = ev_sync_reg[1] && !ev_sync_reg[2];
   assign lines_pending = wr_line_reg - rd_line_reg;
   assign buf_req = capturing && (cof_in.valid || ext_pulse);
   assign buf_we = buf_req && !lines_pending[6];
   assign flush = !capturing && wr_half_reg;
   assign line_ready = lines_pending != 7'h00;

   always_comb
   begin
      info = 8'h00;
      info[1:0] = cof_in.valid ? cof_in.kind : TPO_KIND_SOURCE; // RL5 RL4
      info[TPO_INFO_EXTERNAL_EVENT_INDICATOR] = ext_pulse; // RL6
      info[TPO_INFO_TIMESTAMP_ENABLE_BIT] = timestamp_enable_bit_en; // RL7 RL19
      entry = {info, cof_in.valid ? cof_in.addr : last_pc}; // RL6
   end

   // register writes
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         comparator_a_match_data_reg <= TPO_CMP_RESET;
         comparator_a_match_mask_reg <= TPO_MASK_RESET;
         trace_control_low_reg <= TPO_CTRL_RESET;
      end
      else if (reg_wr && !write_block)
      begin
         if (in_word(reg_addr, TPO_OFS_DATA0, TPO_OFS_DATA3) && cmp_write_ok)
            comparator_a_match_data_reg[byte_sel(reg_addr, TPO_OFS_DATA0)*8 +: 8]
               <= reg_wdata; // RL1 RL2
         if (in_word(reg_addr, TPO_OFS_MASK0, TPO_OFS_MASK3) && cmp_write_ok)
            comparator_a_match_mask_reg[byte_sel(reg_addr, TPO_OFS_MASK0)*8 +: 8]
               <= reg_wdata;
         if (reg_addr == TPO_OFS_CTRL)
            trace_control_low_reg <= reg_wdata; // RL21
      end
   end

   // arming, sequencer disarm and start alignment
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         armed_reg <= 1'b0;
         started_reg <= 1'b0;
      end
      else
      begin
         if (seq_to_state0)
            armed_reg <= 1'b0; // RL17
         else if (reg_wr && !write_block && reg_addr == TPO_OFS_CTRL)
            armed_reg <= reg_wdata[TPO_CTL_ARM];
         if (!armed_reg)
            started_reg <= 1'b0;
         else if (align_eff == TPO_ALIGN_BEGIN)
            started_reg <= started_reg || seq_final_state; // RL15
         else
            started_reg <= 1'b1; // RL14
      end
   end

   // overflow flag: set wins over the clear done by a fresh arming
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         buffer_overflow_flag_reg <= 1'b0;
      else if (buf_req && lines_pending[6])
         buffer_overflow_flag_reg <= 1'b1; // RL15 RL17 RL18
      else if (reg_wr && !write_block && reg_addr == TPO_OFS_CTRL && !armed_reg
               && reg_wdata[TPO_CTL_ARM])
         buffer_overflow_flag_reg <= 1'b0;
   end

   // busy covers a line in flight and lines still waiting
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         stream_busy_flag_reg <= 1'b0;
      else
         stream_busy_flag_reg <= (tx_reg != TPO_TX_IDLE) || line_ready || tx_load
                                 || wr_half_reg; // RL18
   end

   // event pin synchroniser and edge finder
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         ev_sync_reg <= 3'h0;
      else
         ev_sync_reg <= {ev_sync_reg[1:0], ext_event_pin};
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         timestamp_enable_bit_reg <= 32'h0000_0000;
      else
         timestamp_enable_bit_reg <= timestamp_enable_bit_reg + 32'h0000_0001;
   end

   // buffer write pointer; a lone half line is closed once capture ends
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         wr_line_reg <= 7'h00;
         wr_half_reg <= 1'b0;
      end
      else if (buf_we)
      begin
         if (timestamp_enable_bit_en || wr_half_reg)
         begin
            wr_line_reg <= wr_line_reg + 7'h01;
            wr_half_reg <= 1'b0;
         end
         else
            wr_half_reg <= 1'b1; // RL5
      end
      else if (flush)
      begin
         wr_line_reg <= wr_line_reg + 7'h01;
         wr_half_reg <= 1'b0; // RL17
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (buf_we)
      begin
         if (timestamp_enable_bit_en)
            buf_mem[wr_line_reg[5:0]] <= {timestamp_enable_bit_reg, entry}; // RL7 RL8
         else if (wr_half_reg)
            buf_mem[wr_line_reg[5:0]][63:32] <= entry; // RL5
         else
            buf_mem[wr_line_reg[5:0]] <= {32'h0000_0000, entry};
      end
   end

   // serial transmitter: one bit per two bus cycles, clock high in the second
   assign tx_load = line_ready && !buf_we && stream_en
                    && ((tx_reg == TPO_TX_IDLE)
                        || (tx_reg == TPO_TX_HIGH && bit_cnt_reg == TPO_LAST_BIT)); // RL11

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         tx_reg <= TPO_TX_IDLE;
         shift_reg <= 64'h0000_0000_0000_0000;
         bit_cnt_reg <= 6'h00;
         rd_line_reg <= 7'h00;
      end
      else
      begin
         case (tx_reg)
            TPO_TX_IDLE:
            begin
               if (tx_load)
               begin
                  shift_reg <= buf_mem[rd_line_reg[5:0]]; // RL10
                  rd_line_reg <= rd_line_reg + 7'h01;
                  bit_cnt_reg <= 6'h00;
                  tx_reg <= TPO_TX_LOW;
               end
            end
            TPO_TX_LOW:
               tx_reg <= TPO_TX_HIGH;
            TPO_TX_HIGH:
            begin
               if (bit_cnt_reg != TPO_LAST_BIT)
               begin
                  shift_reg <= {1'b0, shift_reg[63:1]}; // RL10
                  bit_cnt_reg <= bit_cnt_reg + 6'h01;
                  tx_reg <= TPO_TX_LOW;
               end
               else if (tx_load)
               begin
                  shift_reg <= buf_mem[rd_line_reg[5:0]];
                  rd_line_reg <= rd_line_reg + 7'h01;
                  bit_cnt_reg <= 6'h00;
                  tx_reg <= TPO_TX_LOW;
               end
               else
                  tx_reg <= TPO_TX_IDLE; // RL12
            end
            default:
               tx_reg <= TPO_TX_IDLE;
         endcase
      end
   end

   // pins follow the shifter with one flop; clock rises mid bit
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         stream_data_pin_o <= 1'b0;
         stream_clock_pin_o <= 1'b0;
         stream_data_pin_oe <= 1'b0;
         stream_clock_pin_oe <= 1'b0;
      end
      else
      begin
         if (tx_load)
            stream_data_pin_o <= buf_mem[rd_line_reg[5:0]][0]; // RL9 RL10
         else if (tx_reg == TPO_TX_HIGH && bit_cnt_reg != TPO_LAST_BIT)
            stream_data_pin_o <= shift_reg[1];
         stream_clock_pin_o <= (tx_reg == TPO_TX_LOW); // RL9 RL12
         stream_data_pin_oe <= trace_control_low_reg[TPO_CTL_PINS]; // RL13
         stream_clock_pin_oe <= trace_control_low_reg[TPO_CTL_PINS];
      end
   end

   // comparator A data match
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         comparator_a_hit <= 1'b0;
      else
         comparator_a_hit <= bus_valid && &(~(bus_data ^ comparator_a_match_data_reg)
                                            | ~comparator_a_match_mask_reg); // RL3
   end

   // register reads, data one cycle after the strobe
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         reg_rdata <= 8'h00;
         tbr_ptr_reg <= 3'h0;
      end
      else
      begin
         reg_rdata <= 8'h00;
         if (reg_rd)
         begin
            if (in_word(reg_addr, TPO_OFS_DATA0, TPO_OFS_DATA3))
               reg_rdata <= comparator_a_match_data_reg[byte_sel(reg_addr, TPO_OFS_DATA0)*8 +: 8];
            else if (in_word(reg_addr, TPO_OFS_MASK0, TPO_OFS_MASK3))
               reg_rdata <= comparator_a_match_mask_reg[byte_sel(reg_addr, TPO_OFS_MASK0)*8 +: 8];
            else if (reg_addr == TPO_OFS_CTRL)
               reg_rdata <= {trace_control_low_reg[7:1], armed_reg};
            else if (reg_addr == TPO_OFS_STAT)
               reg_rdata <= {5'h00, armed_reg, buffer_overflow_flag_reg, stream_busy_flag_reg};
            else if (reg_addr == TPO_OFS_LCNT)
               reg_rdata <= {1'b0, wr_line_reg[5:0], wr_half_reg}; // RL5
            else if (reg_addr == TPO_OFS_TBUF)
            begin
               if (write_block)
                  reg_rdata <= TPO_TBUF_BUSY_CODE; // RL22
               else
               begin
                  reg_rdata <= buf_mem[rd_line_reg[5:0]][tbr_ptr_reg*8 +: 8];
                  tbr_ptr_reg <= tbr_ptr_reg + 3'h1;
               end
            end
         end
      end
   end

   a_cmp_write_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reg_wr && in_word(reg_addr, TPO_OFS_DATA0, TPO_OFS_DATA3) && !cmp_write_ok
      |=> $stable(comparator_a_match_data_reg)) // RL1
      else $error("comparator data changed while locked");
   a_ctrl_write_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reg_wr && reg_addr == TPO_OFS_CTRL && write_block && !seq_to_state0
      |=> $stable(trace_control_low_reg)) // RL21
      else $error("control written while draining");
   a_tbuf_busy_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reg_rd && reg_addr == TPO_OFS_TBUF && write_block
      |=> reg_rdata == 8'hEE) // RL22
      else $error("buffer read port did not return busy code");
   a_tx_start_gap: assert property (@(posedge clk_sys) disable iff (!reset_n)
      tx_reg == TPO_TX_IDLE && line_ready && stream_en && !buf_we
      |=> tx_reg == TPO_TX_LOW ##1 stream_clock_pin_o) // RL11
      else $error("transmission did not start in free cycle");
   a_clk_offset: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(stream_clock_pin_o) |-> $stable(stream_data_pin_o)) // RL9
      else $error("data moved at the clock high phase");
   a_clk_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      tx_reg == TPO_TX_IDLE ##1 tx_reg == TPO_TX_IDLE |-> !stream_clock_pin_o) // RL12
      else $error("output clock moved while paused");
   a_ovf_stop: assert property (@(posedge clk_sys) disable iff (!reset_n)
      buffer_overflow_flag_reg |-> !buf_we) // RL17
      else $error("entry written after overflow");
   a_lsb_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
      tx_load |=> stream_data_pin_o == shift_reg[0]) // RL10
      else $error("first bit sent was not the lsb");
   a_mid_as_end: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(armed_reg) && align_eff != TPO_ALIGN_BEGIN |=> started_reg) // RL14 RL16
      else $error("end aligned streaming did not start on arming");
   a_cmp_match: assert property (@(posedge clk_sys) disable iff (!reset_n)
      bus_valid && comparator_a_match_mask_reg == 32'hFFFF_FFFF
      && bus_data == comparator_a_match_data_reg |=> comparator_a_hit) // RL3
      else $error("full mask exact match missed");

   c_line_sent: cover property (@(posedge clk_sys) disable iff (!reset_n)
      tx_load ##129 tx_reg == TPO_TX_IDLE);
   c_overflow: cover property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(buffer_overflow_flag_reg));
   c_ext_cof: cover property (@(posedge clk_sys) disable iff (!reset_n)
      buf_we && ext_pulse && cof_in.valid);
endmodule : tpo_trace

// ---- verif/tpo_probe.sv ----
// capture probe model: rebuilds 64 bit lines from the stream pins, lsb first
// assumes the stream clock runs at no more than half of clk_sys; pins read low when off
module tpo_probe
   import tpo_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // stream pins as seen on the board
   input wire logic data_pin,
   input wire logic clock_pin,
   // captured lines
   output logic [63:0] line_reg,
   output logic [15:0] lines_reg
);
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_q_reg;
   logic [5:0] bit_reg;
   logic [63:0] shift_reg;

   // sample on the stream clock rise only, so a clock held steady is just a pause
   always_ff @(posedge clk_sys)
   begin
      clk_q_reg <= clock_pin;
      if (!reset_n)
      begin
         bit_reg <= 6'h00;
         lines_reg <= 16'h0000;
         line_reg <= 64'h0;
      end
      else if (clock_pin && !clk_q_reg)
      begin
         shift_reg <= {data_pin, shift_reg[63:1]};
         bit_reg <= bit_reg + 6'h01;
         if (bit_reg == TPO_LAST_BIT)
         begin
            line_reg <= {data_pin, shift_reg[63:1]};
            lines_reg <= lines_reg + 16'h0001;
         end
      end
   end
endmodule : tpo_probe

// ---- verif/testbench.sv ----
// bench of the trace streaming unit: register tasks, entry injection, probe
// assumes the package constants and the hand-over timing of the register port
module testbench
   import tpo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys;
   logic reset_n;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   tpo_cof_t cof_in;
   logic [23:0] last_pc;
   logic seq_final_state;
   logic seq_to_state0;
   logic [31:0] bus_data;
   logic bus_valid;
   logic comparator_a_hit;
   logic ext_event_pin;
   logic sd_o, sd_oe, sc_o, sc_oe;
   logic [63:0] p_line;
   logic [15:0] p_lines;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   // an undriven pin is pulled low on the board
   wire logic pd_wire = sd_oe ? sd_o : 1'b0;
   wire logic pc_wire = sc_oe ? sc_o : 1'b0;

   tpo_trace tpo_trace_inst (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cof_in(cof_in), .last_pc(last_pc), .seq_final_state(seq_final_state),
      .seq_to_state0(seq_to_state0), .bus_data(bus_data), .bus_valid(bus_valid),
      .comparator_a_hit(comparator_a_hit), .ext_event_pin(ext_event_pin),
      .stream_data_pin_o(sd_o), .stream_data_pin_oe(sd_oe),
      .stream_clock_pin_o(sc_o), .stream_clock_pin_oe(sc_oe));
   tpo_probe tpo_probe_inst (.clk_sys(clk_sys), .reset_n(reset_n), .data_pin(pd_wire),
      .clock_pin(pc_wire), .line_reg(p_line), .lines_reg(p_lines));

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // the whole run is near 9700 cycles
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc

   // a gap cycle after each strobe keeps every signal to one assignment a step
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge clk_sys);
   endtask : rd

   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : rdc

   task automatic push(input tpo_cof_t q[$]);
      foreach (q[k])
      begin
         cof_in <= q[k];
         @(posedge clk_sys);
      end
      cof_in <= '0;
      @(posedge clk_sys);
   endtask : push

   // the trailing cycles let busy settle before software touches control again
   task automatic wait_line(input logic [15:0] n);
      int k;
      k = 0;
      while (p_lines < n && k < 9000)
      begin
         @(posedge clk_sys);
         k++;
      end
      chk(p_lines, n);
      cyc(8);
   endtask : wait_line

   function automatic tpo_cof_t mk(input logic [1:0] k);
      return '{1'b1, k, 24'($urandom)};
   endfunction : mk

   function automatic logic [31:0] ent(input tpo_cof_t c, input logic stp);
      return {1'b0, stp, 4'h0, c.kind, c.addr};
   endfunction : ent

   initial
   begin
      logic [31:0] cmp;
      logic [31:0] msk;
      logic [31:0] b;
      logic [7:0] d;
      logic [15:0] base;
      tpo_cof_t e[$];
      tpo_cof_t f[$];
      int i;
      reset_n = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cof_in = '0;
      last_pc = 24'h000000;
      seq_final_state = 1'b0;
      seq_to_state0 = 1'b0;
      bus_data = 32'h0;
      bus_valid = 1'b0;
      ext_event_pin = 1'b0;
      void'($urandom(44450));
      cyc(4);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      for (i = 0; i < 4; i++)
         rdc(TPO_OFS_DATA0 + 16'(i), 8'h00);
      rdc(TPO_OFS_CTRL, TPO_CTRL_RESET);
      rdc(TPO_OFS_STAT, 8'h00);
      rdc(16'h0200, 8'h00);
      $display("test reset done");
      cmp = $urandom;
      msk = $urandom | 32'h0000_0001;
      for (i = 0; i < 4; i++)
      begin
         wr(TPO_OFS_DATA0 + 16'(i), cmp[31 - 8 * i -: 8]);
         wr(TPO_OFS_MASK0 + 16'(i), msk[31 - 8 * i -: 8]);
      end
      for (i = 0; i < 4; i++)
         rdc(TPO_OFS_DATA0 + 16'(i), cmp[31 - 8 * i -: 8]);
      for (i = 0; i < 8; i++)
      begin
         b = $urandom;
         if (i[0] == 1'b0)
            b = cmp ^ (b & ~msk);
         bus_data <= b;
         bus_valid <= 1'b1;
         @(posedge clk_sys);
         bus_valid <= 1'b0;
         #1 chk(comparator_a_hit, ((b ^ cmp) & msk) == 32'h0);
         @(posedge clk_sys);
      end
      $display("test comparator done");
      wr(TPO_OFS_CTRL, 8'h07);
      wr(TPO_OFS_DATA0, ~cmp[31:24]);
      rdc(TPO_OFS_DATA0, cmp[31:24]);
      #1 chk(sd_oe, 1'b1);
      e = '{mk(TPO_KIND_SOURCE), mk(TPO_KIND_DEST)};
      f = '{mk(TPO_KIND_VECTOR), mk(TPO_KIND_DEST)};
      push(e);
      push(f);
      cyc(20);
      rdc(TPO_OFS_STAT, 8'h05);
      wait_line(16'h0001);
      chk(p_line, {ent(e[1], 1'b0), ent(e[0], 1'b0)});
      wait_line(16'h0002);
      chk(p_line, {ent(f[1], 1'b0), ent(f[0], 1'b0)});
      $display("test end aligned stream done");
      last_pc <= 24'($urandom);
      ext_event_pin <= 1'b1;
      cyc(6);
      ext_event_pin <= 1'b0;
      seq_to_state0 <= 1'b1;
      @(posedge clk_sys);
      seq_to_state0 <= 1'b0;
      wr(TPO_OFS_CTRL, 8'h07);
      rdc(TPO_OFS_TBUF, TPO_TBUF_BUSY_CODE);
      rdc(TPO_OFS_STAT, 8'h01);
      wait_line(16'h0003);
      chk({p_line[63:31], p_line[23:0]}, {33'h1, last_pc});
      cyc(10);
      rdc(TPO_OFS_STAT, 8'h00);
      $display("test event and disarm done");
      wr(TPO_OFS_CTRL, 8'h17);
      e = '{mk(TPO_KIND_DEST), mk(TPO_KIND_SOURCE)};
      // the synchronised event edge lands on the first entry of the line
      ext_event_pin <= 1'b1;
      cyc(2);
      push(e);
      ext_event_pin <= 1'b0;
      wait_line(16'h0004);
      chk(p_line, {ent(e[1], 1'b0), ent(e[0], 1'b0) | 32'h8000_0000});
      wr(TPO_OFS_CTRL, 8'h00);
      wr(TPO_OFS_CTRL, 8'h27);
      e = '{mk(TPO_KIND_SOURCE), mk(TPO_KIND_DEST)};
      push(e);
      cyc(150);
      chk(p_lines, 16'h0004);
      seq_final_state <= 1'b1;
      @(posedge clk_sys);
      e = '{mk(TPO_KIND_VECTOR), mk(TPO_KIND_SOURCE)};
      push(e);
      wait_line(16'h0005);
      chk(p_line, {ent(e[1], 1'b0), ent(e[0], 1'b0)});
      $display("test alignment done");
      wr(TPO_OFS_CTRL, 8'h00);
      seq_final_state <= 1'b0;
      wr(TPO_OFS_CTRL, 8'h0F);
      e = '{mk(TPO_KIND_SOURCE)};
      push(e);
      wait_line(16'h0006);
      chk(p_line[31:0], ent(e[0], 1'b1));
      $display("test timestamp done");
      wr(TPO_OFS_CTRL, 8'h00);
      wr(TPO_OFS_CTRL, 8'h07);
      base = p_lines;
      e.delete();
      for (i = 0; i < 130; i++)
         e.push_back(mk(TPO_KIND_DEST));
      push(e);
      rd(TPO_OFS_STAT, d);
      chk(d[TPO_ST_OVF], 1'b1);
      wait_line(base + 16'h0040);
      cyc(300);
      chk(p_lines, base + 16'h0040);
      $display("test overflow done");
      wr(TPO_OFS_CTRL, 8'h00);
      wr(TPO_OFS_CTRL, 8'h03);
      #1 chk({sd_oe, sc_oe}, 2'b00);
      wr(TPO_OFS_CTRL, 8'h00);
      $display("test pin enable done");
      wrap_up();
   end
endmodule : testbench
